/* File: rrfc_map.vh */
// Register map, field positions and timing constants for the receiver configuration bank
// Function
// - Start marker with enable raises frame start interrupt
// - Start marker sets sticky seen flag
// - Subcarrier with enable raises same interrupt
// - Subcarrier sets sticky seen flag
// - Live subcarrier flag, not latched
// - Partial byte store keeps incomplete last byte
// - Continuous receive keeps receiver active after frame
// - Continuous receive appends error copy byte
// - End style selects configured or Type B marker
// - Style 0 with symbol bits 00 skips check
// - Guard time check flags overlong gap in Type B frames
// - Early error discards bytes, resets FIFO
// - Short frame after start marker is disturbance
// - No receive done for discarded frames
// - Three bit code selects receive bit rate
// - Hold-off unit sixteen carriers or half bit
// - Seven bit hold-off ignores input after transmit, except subcarrier detection
// - Decoder minimum threshold field
// - Phase detector minimum threshold field
// - Half bit uses transmit data bit rate
`ifndef RRFC_MAP_VH
`define RRFC_MAP_VH
// Register indices, byte address is four times the index
`define RRFC_IDX_SOFD 8'h34
`define RRFC_IDX_CTRL 8'h35
`define RRFC_IDX_WAIT 8'h36
`define RRFC_IDX_THR 8'h37
// Frame start detect fields
`define RRFC_B_SOF_EN 5
`define RRFC_B_SOF_SEEN 4
`define RRFC_B_SUBCARRIER_IRQ_ENABLE 2
`define RRFC_B_SUBC_SEEN 1
`define RRFC_B_SUBC_NOW 0
// Receive control fields
`define RRFC_B_PARTIAL 7
`define RRFC_B_CONT 6
`define RRFC_B_EOF_STYLE 5
`define RRFC_B_EGT 4
`define RRFC_B_EMD 3
`define RRFC_F_RATE 2:0
// Hold-off fields
`define RRFC_B_HOLD_UNIT 7
`define RRFC_F_HOLD 6:0
// Threshold fields
`define RRFC_F_DEC_THR 7:4
`define RRFC_F_PH_THR 3:0
// Reset values, not documented: all zero
`define RRFC_RST_BYTE 8'h00
// Timing in carrier cycles, early error limit in bytes
`define RRFC_HOLD_CARRIERS 11'h010
`define RRFC_HALF_BIT_BASE 11'h400
`define RRFC_EMD_BYTES 2'h3
// AXI responses
`define RRFC_RESP_OKAY 2'h0
`define RRFC_RESP_SLVERR 2'h2
`endif

/* File: rrfc_top.v */
// Receiver configuration register bank with receive frame control logic
//
// The AXI4-Lite interface to the registers was left to the implementer.
`include "rrfc_map.vh"
module rrfc_top #(
  parameter EGT_LIMIT = 16'h0100 // Longest guard gap in carrier cycles
) (
  input wire clk, // 100 MHz system clock
  input wire sys_rst, // Asynchronous reset, active high
  input wire [31:0] s_axi_awaddr, // Write address
  input wire s_axi_awvalid, // Write address valid
  output wire s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire [3:0] s_axi_wstrb, // Write byte enables
  input wire s_axi_wvalid, // Write data valid
  output wire s_axi_wready, // Write data ready
  output reg [1:0] s_axi_bresp, // Write response
  output reg s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [31:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid, // Read address valid
  output wire s_axi_arready, // Read address ready
  output reg [31:0] s_axi_rdata, // Read data
  output reg [1:0] s_axi_rresp, // Read response
  output reg s_axi_rvalid, // Read data valid
  input wire s_axi_rready, // Read data ready
  input wire carrier_tick, // One pulse per carrier cycle
  input wire sof_pulse, // Start marker detected
  input wire subc_level, // Subcarrier currently detected
  input wire tx_end, // Transmission finished
  input wire rx_start, // Receive command issued
  input wire [2:0] bit_stream_rate, // Transmit data rate code
  input wire [1:0] end_symbol_config, // End symbol selection bits
  input wire crc_en, // Checksum enabled
  input wire [7:0] error_copy, // Current error register value
  input wire rx_byte_valid, // Received byte strobe
  input wire [7:0] rx_byte, // Received byte
  input wire rx_byte_partial, // Byte is incomplete
  input wire rx_fault, // Error or collision on this byte
  input wire rx_frame_end, // End of received data stream
  output reg frame_start_interrupt, // Start or subcarrier interrupt
  output reg receive_done_interrupt, // Frame received pulse
  output reg rx_active, // Receiver enabled
  output reg rx_ignore, // Hold-off window running
  output reg fifo_wr_valid, // FIFO write strobe
  output reg [7:0] fifo_wr_data, // FIFO write data
  output reg fifo_reset, // FIFO flush pulse
  output reg protocol_error, // Guard time too long pulse
  output reg eof_check_en, // End marker check enabled
  output reg eof_type_b, // Type B end marker expected
  output reg [1:0] eof_symbol_sel, // Configured end symbol
  output reg [2:0] receive_rate, // Receive bit rate code
  output reg [3:0] decoder_min_threshold, // Bit decoder level
  output reg [3:0] phase_min_threshold // Phase detector level
);

  // Half bit period in carrier cycles for a rate code
  function [10:0] half_bit;
    input [2:0] code;
    begin
      half_bit = `RRFC_HALF_BIT_BASE >> code;
    end
  endfunction

  // Register index from a byte address, with word alignment check
  function [8:0] reg_index;
    input [31:0] addr;
    begin
      reg_index = {|addr[31:10] | |addr[1:0], addr[9:2]};
    end
  endfunction

  reg sof_en_reg, sof_seen_reg, subcarrier_irq_enable_reg, subc_seen_reg, subc_now_reg;
  reg [7:0] ctrl_reg, wait_reg, thr_reg;
  reg aw_held_reg, w_held_reg;
  reg [31:0] awaddr_reg;
  reg [7:0] wdata_reg;
  reg wstrb0_reg;
  reg subc_prev_reg;
  reg [6:0] hold_cnt_reg;
  reg [10:0] sub_cnt_reg;
  reg [1:0] byte_cnt_reg;
  reg frame_open_reg;
  reg [15:0] gap_cnt_reg;
  reg err_pend_reg;

  wire wr_go = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  wire [8:0] wr_idx = reg_index(awaddr_reg);
  wire [8:0] rd_idx = reg_index(s_axi_araddr);
  wire wr_sofd = wr_go & wstrb0_reg & (wr_idx == {1'b0, `RRFC_IDX_SOFD});
  wire subc_rise = subc_level & ~subc_prev_reg;
  wire emd_on = ctrl_reg[`RRFC_B_EMD];
  wire byte_in = rx_byte_valid & rx_active & ~rx_ignore;
  wire end_in = rx_frame_end & rx_active & ~rx_ignore;
  wire sof_in = sof_pulse & ~rx_ignore;
  wire [10:0] unit_len = wait_reg[`RRFC_B_HOLD_UNIT] ?
    half_bit(bit_stream_rate) : `RRFC_HOLD_CARRIERS;

  // Address and data are taken in either order, one write at a time
  assign s_axi_awready = ~aw_held_reg;
  assign s_axi_wready = ~w_held_reg;
  assign s_axi_arready = ~s_axi_rvalid;

  // Write channel capture and response
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 32'h00000000;
      wdata_reg <= `RRFC_RST_BYTE;
      wstrb0_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RRFC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & ~aw_held_reg) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid & ~w_held_reg) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata[7:0];
        wstrb0_reg <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Whole aligned word group compared at nine bits on both sides
        s_axi_bresp <= ({wr_idx[8:2], 2'h0} == {1'b0, `RRFC_IDX_SOFD}) ?
          `RRFC_RESP_OKAY : `RRFC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Writable fields; bytes outside lane zero are ignored
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sof_en_reg <= 1'b0;
      subcarrier_irq_enable_reg <= 1'b0;
      ctrl_reg <= `RRFC_RST_BYTE;
      wait_reg <= `RRFC_RST_BYTE;
      thr_reg <= `RRFC_RST_BYTE;
    end else if (wr_go & wstrb0_reg) begin
      if (wr_idx == {1'b0, `RRFC_IDX_SOFD}) begin
        sof_en_reg <= wdata_reg[`RRFC_B_SOF_EN];
        subcarrier_irq_enable_reg <= wdata_reg[`RRFC_B_SUBCARRIER_IRQ_ENABLE];
      end
      if (wr_idx == {1'b0, `RRFC_IDX_CTRL})
        ctrl_reg <= wdata_reg;
      if (wr_idx == {1'b0, `RRFC_IDX_WAIT})
        wait_reg <= wdata_reg;
      if (wr_idx == {1'b0, `RRFC_IDX_THR})
        thr_reg <= wdata_reg;
    end
  end

  // Sticky detection flags; a new event beats a same-cycle clear
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sof_seen_reg <= 1'b0;
      subc_seen_reg <= 1'b0;
      subc_now_reg <= 1'b0;
      subc_prev_reg <= 1'b0;
      frame_start_interrupt <= 1'b0;
    end else begin
      subc_prev_reg <= subc_level;
      subc_now_reg <= subc_level;
      if (sof_in)
        sof_seen_reg <= 1'b1;
      else if (wr_sofd & ~wdata_reg[`RRFC_B_SOF_SEEN])
        sof_seen_reg <= 1'b0;
      if (subc_rise)
        subc_seen_reg <= 1'b1;
      else if (wr_sofd & ~wdata_reg[`RRFC_B_SUBC_SEEN])
        subc_seen_reg <= 1'b0;
      // One pulse per cycle with a qualifying event, both sources share the line
      frame_start_interrupt <= (sof_en_reg & sof_in) |
        (subcarrier_irq_enable_reg & subc_rise);
    end
  end

  // Read channel: one cycle after the address is taken
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RRFC_RESP_OKAY;
    end else if (s_axi_arvalid & ~s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RRFC_RESP_OKAY;
      case (rd_idx)
        {1'b0, `RRFC_IDX_SOFD}:
          s_axi_rdata <= {26'h0000000, sof_en_reg, sof_seen_reg, 1'b0,
            subcarrier_irq_enable_reg, subc_seen_reg, subc_now_reg};
        {1'b0, `RRFC_IDX_CTRL}: s_axi_rdata <= {24'h000000, ctrl_reg};
        {1'b0, `RRFC_IDX_WAIT}: s_axi_rdata <= {24'h000000, wait_reg};
        {1'b0, `RRFC_IDX_THR}: s_axi_rdata <= {24'h000000, thr_reg};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RRFC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Static settings handed to the receiver datapath
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      eof_check_en <= 1'b0;
      eof_type_b <= 1'b0;
      eof_symbol_sel <= 2'h0;
      receive_rate <= 3'h0;
      decoder_min_threshold <= 4'h0;
      phase_min_threshold <= 4'h0;
    end else begin
      eof_type_b <= ctrl_reg[`RRFC_B_EOF_STYLE];
      eof_symbol_sel <= end_symbol_config;
      eof_check_en <= ctrl_reg[`RRFC_B_EOF_STYLE] | (|end_symbol_config);
      receive_rate <= ctrl_reg[`RRFC_F_RATE];
      decoder_min_threshold <= thr_reg[`RRFC_F_DEC_THR];
      phase_min_threshold <= thr_reg[`RRFC_F_PH_THR];
    end
  end

  // Hold-off after transmit; a zero count gives no window at all
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_ignore <= 1'b0;
      hold_cnt_reg <= 7'h00;
      sub_cnt_reg <= 11'h000;
    end else if (tx_end) begin
      hold_cnt_reg <= wait_reg[`RRFC_F_HOLD];
      rx_ignore <= |wait_reg[`RRFC_F_HOLD];
      sub_cnt_reg <= 11'h000;
    end else if (rx_ignore & carrier_tick) begin
      if (sub_cnt_reg == unit_len - 11'h001) begin
        sub_cnt_reg <= 11'h000;
        hold_cnt_reg <= hold_cnt_reg - 7'h01;
        if (hold_cnt_reg == 7'h01)
          rx_ignore <= 1'b0;
      end else begin
        sub_cnt_reg <= sub_cnt_reg + 11'h001;
      end
    end
  end

  // Frame datapath: FIFO writes, disturbance filter, error byte
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_active <= 1'b0;
      frame_open_reg <= 1'b0;
      byte_cnt_reg <= 2'h0;
      gap_cnt_reg <= 16'h0000;
      err_pend_reg <= 1'b0;
      fifo_wr_valid <= 1'b0;
      fifo_wr_data <= `RRFC_RST_BYTE;
      fifo_reset <= 1'b0;
      receive_done_interrupt <= 1'b0;
      protocol_error <= 1'b0;
    end else begin
      fifo_wr_valid <= 1'b0;
      fifo_reset <= 1'b0;
      receive_done_interrupt <= 1'b0;
      protocol_error <= 1'b0;
      if (rx_start)
        rx_active <= 1'b1;
      if (sof_in & rx_active) begin
        frame_open_reg <= 1'b1;
        byte_cnt_reg <= 2'h0;
        gap_cnt_reg <= 16'h0000;
      end
      // Guard gap counted between bytes of any open frame
      if (frame_open_reg & carrier_tick & ~byte_in)
        gap_cnt_reg <= gap_cnt_reg + 16'h0001;
      if (byte_in) begin
        gap_cnt_reg <= 16'h0000;
        if (ctrl_reg[`RRFC_B_EGT] & ctrl_reg[`RRFC_B_EOF_STYLE] &
            (gap_cnt_reg > EGT_LIMIT) & (byte_cnt_reg != 2'h0))
          protocol_error <= 1'b1;
        if (emd_on & rx_fault & (byte_cnt_reg < `RRFC_EMD_BYTES)) begin
          fifo_reset <= 1'b1;
          byte_cnt_reg <= 2'h0;
          frame_open_reg <= 1'b0;
        end else begin
          if (byte_cnt_reg < `RRFC_EMD_BYTES)
            byte_cnt_reg <= byte_cnt_reg + 2'h1;
          // Incomplete byte is dropped only when checksum is on
          if (~rx_byte_partial | ~crc_en | ctrl_reg[`RRFC_B_PARTIAL]) begin
            fifo_wr_valid <= 1'b1;
            fifo_wr_data <= rx_byte;
          end
        end
      end else if (err_pend_reg) begin
        err_pend_reg <= 1'b0;
        fifo_wr_valid <= 1'b1;
        fifo_wr_data <= error_copy;
      end
      if (end_in) begin
        frame_open_reg <= 1'b0;
        byte_cnt_reg <= 2'h0;
        if (emd_on & frame_open_reg & (byte_cnt_reg < `RRFC_EMD_BYTES)) begin
          fifo_reset <= 1'b1;
        end else if (~emd_on | frame_open_reg) begin
          // A frame already flushed by an early fault ends with no done
          receive_done_interrupt <= 1'b1;
          // Error byte waits one cycle so it never collides with data
          if (ctrl_reg[`RRFC_B_CONT])
            err_pend_reg <= 1'b1;
        end
        if (~ctrl_reg[`RRFC_B_CONT])
          rx_active <= 1'b0;
      end
    end
  end

endmodule

/* File: rrfc_properties.sv */
// Port level assertions for the receiver configuration bank
module rrfc_props (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Async reset
  input wire logic sof_pulse, // Start marker
  input wire logic subc_level, // Subcarrier level
  input wire logic tx_end, // Transmit end
  input wire logic rx_start, // Receive command
  input wire logic [1:0] end_symbol_config, // End symbol bits
  input wire logic rx_byte_valid, // Byte strobe
  input wire logic [7:0] rx_byte, // Byte
  input wire logic rx_byte_partial, // Short byte
  input wire logic rx_fault, // Byte fault
  input wire logic rx_frame_end, // Stream end
  input wire logic frame_start_interrupt, // Start interrupt
  input wire logic receive_done_interrupt, // Done pulse
  input wire logic rx_active, // Receiver on
  input wire logic rx_ignore, // Hold-off
  input wire logic fifo_wr_valid, // FIFO write
  input wire logic [7:0] fifo_wr_data, // FIFO data
  input wire logic fifo_reset, // FIFO flush
  input wire logic protocol_error, // Guard error
  input wire logic eof_check_en // End check on
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Interrupt needs a marker or a subcarrier rise, both one cycle back
  irq_cause_a: assert property (frame_start_interrupt |-> $past(sof_pulse) ||
    ($past(subc_level) && !$past(subc_level, 2))) else $error("interrupt without cause");
  // Clean accepted byte lands in the FIFO one cycle later, unchanged
  byte_store_a: assert property (rx_byte_valid && rx_active && !rx_ignore && !rx_fault
    && !rx_byte_partial |=> fifo_wr_valid && fifo_wr_data == $past(rx_byte))
    else $error("byte not stored");
  done_cause_a: assert property (receive_done_interrupt |-> $past(rx_frame_end))
    else $error("done without frame end");
  flush_no_done_a: assert property (fifo_reset |-> !receive_done_interrupt && !fifo_wr_valid)
    else $error("flush with done or write");
  start_active_a: assert property (rx_start |=> rx_active)
    else $error("receiver not started");
  eof_check_a: assert property (end_symbol_config != 2'h0 |=> eof_check_en)
    else $error("end check off");
  guard_err_a: assert property (protocol_error |-> $past(rx_byte_valid))
    else $error("guard error without byte");
  holdoff_start_a: assert property ($rose(rx_ignore) |-> $past(tx_end))
    else $error("hold-off without transmit end");
  cover property (fifo_reset);
  cover property (receive_done_interrupt && rx_active);
  cover property (protocol_error);
endmodule
bind rrfc_top rrfc_props chk (.*);

/* File: rrfc_card.sv */
// Behavioural card that produces received frame events
module rrfc_card (
  input wire logic clk, // System clock
  output logic sof_pulse, // Start marker
  output logic subc_level, // Subcarrier level
  output logic rx_byte_valid, // Byte strobe
  output logic [7:0] rx_byte, // Byte value
  output logic rx_byte_partial, // Short last byte
  output logic rx_fault, // Error or collision
  output logic rx_frame_end // Stream end
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle field, byte lines parked on a pattern
  initial begin
    {sof_pulse, subc_level, rx_byte_valid, rx_byte_partial, rx_fault, rx_frame_end} = '0;
    rx_byte = 8'h3C;
  end
  task automatic mark();
    @(posedge clk);
    sof_pulse <= 1'b1;
    @(posedge clk);
    sof_pulse <= 1'b0;
  endtask
  task automatic carrier(input bit v);
    @(posedge clk);
    subc_level <= v;
  endtask
  // Released byte bus shows the inverse of the last byte
  task automatic idle_bytes();
    rx_byte_valid <= 1'b0;
    rx_byte <= ~rx_byte;
    rx_fault <= 1'b0;
    rx_byte_partial <= 1'b0;
  endtask
  // Marker, n bytes spaced by gap cycles, then end; strobe held between back to back bytes
  task automatic frame(input int n, input int bad, input bit part, input int gap);
    mark();
    for (int i = 0; i < n; i++) begin
      if (gap > 0) begin
        idle_bytes();
        repeat (gap) @(posedge clk);
      end
      rx_byte_valid <= 1'b1;
      rx_byte <= 8'hA0 + i[7:0];
      rx_fault <= (i == bad);
      rx_byte_partial <= part && (i == n - 1);
      @(posedge clk);
    end
    idle_bytes();
    @(posedge clk);
    rx_frame_end <= 1'b1;
    @(posedge clk);
    rx_frame_end <= 1'b0;
  endtask
endmodule

/* File: tb_rf_receiver_frame_config.sv */
// Register and frame tests for the receiver configuration bank
module tb_rf_receiver_frame_config;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb, decoder_min_threshold, phase_min_threshold;
  logic [1:0] s_axi_bresp, s_axi_rresp, end_symbol_config, eof_symbol_sel;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic carrier_tick, sof_pulse, subc_level, tx_end, rx_start, crc_en;
  logic [2:0] bit_stream_rate, receive_rate;
  logic [7:0] error_copy, rx_byte, fifo_wr_data, ld;
  logic rx_byte_valid, rx_byte_partial, rx_fault, rx_frame_end;
  logic frame_start_interrupt, receive_done_interrupt, rx_active, rx_ignore;
  logic fifo_wr_valid, fifo_reset, protocol_error, eof_check_en, eof_type_b;
  int err_total, checks, nw, nd, nr, ni, npe, i0;
  rrfc_top #(.EGT_LIMIT(16'h0004)) uut (.*);
  rrfc_card card (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Output events counted off the launching edge
  always @(negedge clk) begin
    nw += fifo_wr_valid;
    nd += receive_done_interrupt;
    nr += fifo_reset;
    ni += frame_start_interrupt;
    npe += protocol_error;
    if (fifo_wr_valid) ld = fifo_wr_data;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Handshakes judged at the falling edge, released after the taking edge
  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(negedge clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) break;
    end
    s_axi_bready <= 1'b0;
    @(negedge clk);
    // A response that never came counts as a mismatch
    chk(tb, 1'b1);
    chk(r, er);
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] e, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(negedge clk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) break;
    end
    s_axi_rready <= 1'b0;
    chk(tr, 1'b1);
    chk(d, {24'h0, e});
    chk({30'h0, r}, {30'h0, er});
  endtask
  // One frame under a control setting; FIFO is never read back mid-frame
  task automatic frm(input logic [7:0] c, input int n, bad, gap, input bit part,
                     input int ew, ed, er);
    int w0, d0, r0;
    wr(32'hD4, c);
    w0 = nw;
    d0 = nd;
    r0 = nr;
    @(posedge clk);
    rx_start <= 1'b1;
    @(posedge clk);
    rx_start <= 1'b0;
    card.frame(n, bad, part, gap);
    repeat (8) @(negedge clk);
    chk(nw - w0, ew);
    chk(nd - d0, ed);
    chk(nr - r0, er);
  endtask
  task automatic ho(input logic [7:0] v, input int lo, input int hi);
    int c;
    wr(32'hD8, v);
    @(posedge clk);
    tx_end <= 1'b1;
    @(posedge clk);
    tx_end <= 1'b0;
    c = 0;
    repeat (200) begin
      @(negedge clk);
      if (rx_ignore === 1'b1) c++;
    end
    chk(c >= lo && c <= hi, 1);
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    summarize();
  end
  initial begin
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, tx_end, rx_start} = '0;
    {bit_stream_rate, end_symbol_config} = '0;
    s_axi_wstrb = 4'hF;
    carrier_tick = 1'b1; // Tick every cycle keeps hold-off spans short
    crc_en = 1'b1;
    error_copy = 8'h5A;
    sys_rst = 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    wr(32'h100, 8'hFF, 2'h2);
    for (int i = 0; i < 4; i++) rd(32'hD0 + 4 * i, 8'h00, 2'h0);
    rd(32'h100, 8'h00, 2'h2);
    wr(32'hDC, 8'hA5);
    rd(32'hDC, 8'hA5, 2'h0);
    chk(decoder_min_threshold, 4'hA);
    chk(phase_min_threshold, 4'h5);
    for (int c = 2; c < 8; c++) begin
      wr(32'hD4, c[7:0]);
      chk(receive_rate, c[2:0]);
    end
    wr(32'hD4, 8'h00);
    chk(eof_check_en, 1'b0);
    wr(32'hD4, 8'h20);
    chk(eof_type_b, 1'b1);
    @(posedge clk);
    end_symbol_config <= 2'h2;
    repeat (2) @(negedge clk);
    chk(eof_symbol_sel, 2'h2);
    chk(eof_check_en, 1'b1);
    wr(32'hD0, 8'h21);
    rd(32'hD0, 8'h20, 2'h0);
    i0 = ni;
    card.mark();
    repeat (3) @(negedge clk);
    chk(ni - i0, 1);
    rd(32'hD0, 8'h30, 2'h0);
    wr(32'hD0, 8'h24);
    rd(32'hD0, 8'h24, 2'h0);
    card.carrier(1'b1);
    repeat (3) @(negedge clk);
    chk(ni - i0, 2);
    rd(32'hD0, 8'h27, 2'h0);
    card.carrier(1'b0);
    rd(32'hD0, 8'h26, 2'h0);
    wr(32'hD0, 8'h00);
    card.mark();
    rd(32'hD0, 8'h10, 2'h0);
    chk(ni - i0, 2);
    frm(8'h00, 4, -1, 0, 0, 4, 1, 0);
    chk(rx_active, 1'b0);
    frm(8'h08, 2, 1, 0, 0, 1, 0, 1);
    frm(8'h08, 2, -1, 0, 0, 2, 0, 1);
    frm(8'h00, 3, -1, 0, 1, 2, 1, 0);
    frm(8'h80, 3, -1, 0, 1, 3, 1, 0);
    frm(8'h30, 2, -1, 10, 0, 2, 1, 0);
    chk(npe != 0, 1);
    frm(8'h40, 3, -1, 0, 0, 4, 1, 0);
    chk(rx_active, 1'b1);
    chk(ld, 8'h5A);
    ho(8'h02, 31, 34);
    ho(8'h00, 0, 0);
    @(posedge clk);
    bit_stream_rate <= 3'h7;
    ho(8'h82, 15, 18);
    rd(32'hD8, 8'h82, 2'h0);
    summarize();
  end
endmodule
